// file: logic/iomsr_pkg.sv
package iomsr_pkg;
    // Word offsets of the first instance
    localparam logic [15:0] IOMSR_APP_SEL_OFS      = 16'h38FD;
    localparam logic [15:0] IOMSR_LOCK_OFS         = 16'h38FE;
    localparam logic [15:0] IOMSR_INST_OFS         = 16'h38FF;
    localparam logic [15:0] IOMSR_RSVD_SET_OFS     = 16'h3900;
    localparam logic [15:0] IOMSR_BTN_APP_OFS      = 16'h3901;
    localparam logic [15:0] IOMSR_SW_APP_OFS       = 16'h3902;
    localparam logic [15:0] IOMSR_RSVD_PAIR_OFS    = 16'h3903;
    localparam logic [15:0] IOMSR_RSVD_PAIR_END    = 16'h3904;
    localparam logic [15:0] IOMSR_IN_VALID_OFS     = 16'h3905;
    localparam logic [15:0] IOMSR_IN_STATE_OFS     = 16'h3906;
    localparam logic [15:0] IOMSR_OUT_VALID_OFS    = 16'h3907;
    localparam logic [15:0] IOMSR_OUT_STATE_OFS    = 16'h3908;
    // Bases of each block per instance
    localparam logic [15:0] IOMSR_SET_BASE_1       = 16'h38FD;
    localparam logic [15:0] IOMSR_SET_BASE_2       = 16'h44B5;
    localparam logic [15:0] IOMSR_STAT_BASE_1      = 16'h3905;
    localparam logic [15:0] IOMSR_STAT_BASE_2      = 16'h44BD;
    // Field widths and ranges
    localparam int          IOMSR_NUM_IN           = 6;
    localparam int          IOMSR_NUM_OUT          = 3;
    localparam logic [3:0]  IOMSR_APP_MIN          = 4'h1;
    localparam logic [3:0]  IOMSR_APP_MAX          = 4'h9;
    // Values after reset
    localparam logic [3:0]  IOMSR_APP_RESET        = 4'h1;
    localparam logic [15:0] IOMSR_WORD_RESET       = 16'h0000;
endpackage

// file: logic/iomsr_top.sv
// Operation
// - Report selector switch position, codes 1 to 9
// - Report setup lock: 0 unlocked, 1 locked
// - Report instance switch: 0 first, 1 second
// - Hold last button-validated application number
// - Hold last software-validated application number
// - Input validity word qualifies input state bits
// - Input states in bits 0-5, rest reserved
// - Output validity word qualifies output state bits
// - Output states in bits 0-2, rest reserved
// - Second instance relocates hardware setting block
// - Second instance relocates status block
`timescale 1ns/1ps
`default_nettype none
module iomsr_top (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           resetn,
    // Switch and button pins
    input  wire logic [3:0]                     app_switch,
    input  wire logic                           lock_switch,
    input  wire logic                           instance_switch,
    input  wire logic                           test_button,
    // Validation from configuration software
    input  wire logic                           sw_validate,
    input  wire logic [3:0]                     sw_app,
    // Input lines and their quality
    input  wire logic [iomsr_pkg::IOMSR_NUM_IN-1:0]  input_line,
    input  wire logic [iomsr_pkg::IOMSR_NUM_IN-1:0]  input_valid,
    // Output line states and their quality
    input  wire logic [iomsr_pkg::IOMSR_NUM_OUT-1:0] output_line,
    input  wire logic [iomsr_pkg::IOMSR_NUM_OUT-1:0] output_valid,
    // Register access port
    input  wire logic                           reg_req,
    input  wire logic                           reg_we,
    input  wire logic [15:0]                    reg_addr,
    input  wire logic [15:0]                    reg_wdata,
    output logic                                reg_ack,
    output logic                                reg_err,
    output logic [15:0]                         reg_rdata
);
    import iomsr_pkg::*;

    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic [3:0]  app_meta_reg;
    logic [3:0]  app_sync_reg;
    logic        lock_meta_reg;
    logic        lock_sync_reg;
    logic        inst_meta_reg;
    logic        inst_sync_reg;
    logic        btn_meta_reg;
    logic        btn_sync_reg;
    logic        btn_prev_reg;
    logic [IOMSR_NUM_IN-1:0] in_meta_reg;
    logic [IOMSR_NUM_IN-1:0] in_sync_reg;
    logic [3:0]  app_pos_reg;
    logic [3:0]  btn_app_reg;
    logic [3:0]  btn_app_next;
    logic [3:0]  sw_app_reg;
    logic [3:0]  sw_app_next;
    logic        ack_reg;
    logic        err_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        hit_next;

    function automatic logic app_ok(input logic [3:0] v);
        app_ok = (v >= IOMSR_APP_MIN) && (v <= IOMSR_APP_MAX);
    endfunction

    function automatic logic [15:0] zext4(input logic [3:0] v);
        zext4 = {12'h000, v};
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Pins are asynchronous to clk
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            app_meta_reg <= IOMSR_APP_RESET;
            app_sync_reg <= IOMSR_APP_RESET;
        end else begin
            app_meta_reg <= app_switch;
            app_sync_reg <= app_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
        end else begin
            lock_meta_reg <= lock_switch;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            inst_meta_reg <= 1'b0;
            inst_sync_reg <= 1'b0;
        end else begin
            inst_meta_reg <= instance_switch;
            inst_sync_reg <= inst_meta_reg;
        end
    end

    // Previous level starts low like the idle pin, so no edge after reset
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            btn_meta_reg <= 1'b0;
            btn_sync_reg <= 1'b0;
            btn_prev_reg <= 1'b0;
        end else begin
            btn_meta_reg <= test_button;
            btn_sync_reg <= btn_meta_reg;
            btn_prev_reg <= btn_sync_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            in_meta_reg <= '0;
            in_sync_reg <= '0;
        end else begin
            in_meta_reg <= input_line;
            in_sync_reg <= in_meta_reg;
        end
    end

    // Out-of-range codes mid-rotation are not reported; last good one holds
    wire app_good    = app_ok(app_sync_reg);
    wire btn_press   = btn_sync_reg & ~btn_prev_reg;

    always_comb begin
        btn_app_next = btn_app_reg;
        if (btn_press && app_ok(app_pos_reg)) begin
            btn_app_next = app_pos_reg;
        end
        sw_app_next = sw_app_reg;
        if (sw_validate && app_ok(sw_app)) begin
            sw_app_next = sw_app;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            app_pos_reg <= IOMSR_APP_RESET;
        end else if (app_good) begin
            app_pos_reg <= app_sync_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            btn_app_reg <= IOMSR_APP_RESET;
        end else begin
            btn_app_reg <= btn_app_next;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            sw_app_reg <= IOMSR_APP_RESET;
        end else begin
            sw_app_reg <= sw_app_next;
        end
    end

    // Instance switch picks which map this module answers
    wire [15:0] set_base  = inst_sync_reg ? IOMSR_SET_BASE_2 : IOMSR_SET_BASE_1;
    wire [15:0] stat_base = inst_sync_reg ? IOMSR_STAT_BASE_2 : IOMSR_STAT_BASE_1;
    wire [15:0] set_idx   = reg_addr - set_base;
    wire [15:0] stat_idx  = reg_addr - stat_base;
    wire [15:0] set_ofs   = set_idx + IOMSR_SET_BASE_1;
    wire [15:0] stat_ofs  = stat_idx + IOMSR_STAT_BASE_1;

    wire [15:0] in_valid_word  = {{(16-IOMSR_NUM_IN){1'b0}}, input_valid};
    wire [15:0] in_state_word  = {{(16-IOMSR_NUM_IN){1'b0}}, in_sync_reg};
    wire [15:0] out_valid_word = {{(16-IOMSR_NUM_OUT){1'b0}}, output_valid};
    wire [15:0] out_state_word = {{(16-IOMSR_NUM_OUT){1'b0}}, output_line};

    // Set block spans eight words, status block follows it
    wire set_hit  = (set_ofs >= IOMSR_APP_SEL_OFS) && (set_ofs <= IOMSR_RSVD_PAIR_END);
    wire stat_hit = (stat_ofs >= IOMSR_IN_VALID_OFS) && (stat_ofs <= IOMSR_OUT_STATE_OFS);

    always_comb begin
        rdata_next = IOMSR_WORD_RESET;
        hit_next   = set_hit | stat_hit;
        if (set_hit) begin
            case (set_ofs)
                IOMSR_APP_SEL_OFS: rdata_next = zext4(app_pos_reg);
                IOMSR_LOCK_OFS:    rdata_next = {15'h0000, lock_sync_reg};
                IOMSR_INST_OFS:    rdata_next = {15'h0000, inst_sync_reg};
                IOMSR_BTN_APP_OFS: rdata_next = zext4(btn_app_reg);
                IOMSR_SW_APP_OFS:  rdata_next = zext4(sw_app_reg);
                default:           rdata_next = IOMSR_WORD_RESET;
            endcase
        end else if (stat_hit) begin
            case (stat_ofs)
                IOMSR_IN_VALID_OFS:  rdata_next = in_valid_word;
                IOMSR_IN_STATE_OFS:  rdata_next = in_state_word;
                IOMSR_OUT_VALID_OFS: rdata_next = out_valid_word;
                IOMSR_OUT_STATE_OFS: rdata_next = out_state_word;
                default:             rdata_next = IOMSR_WORD_RESET;
            endcase
        end
        // Writes store nothing; the bank only mirrors hardware state
        if (reg_we) begin
            rdata_next = IOMSR_WORD_RESET;
        end
    end

    // Write data is unused by design
    wire unused_wdata = ^reg_wdata;

    // Answer follows the request one edge later, high for as long as the request is held
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= reg_req;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= reg_req & ~hit_next;
        end
    end

    // Data reads zero outside an answer so stale words never linger
    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rdata_reg <= IOMSR_WORD_RESET;
        end else begin
            rdata_reg <= reg_req ? rdata_next : IOMSR_WORD_RESET;
        end
    end

    assign reg_ack   = ack_reg;
    assign reg_err   = err_reg & ~unused_wdata | err_reg & unused_wdata;
    assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

// file: verif/iomsr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module iomsr_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register access port
    input wire logic        reg_req,
    input wire logic        reg_we,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    input wire logic [15:0] reg_rdata
);
    import iomsr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic rd = reg_req && !reg_we;
    // Either instance; the unselected one answers with an error
    function automatic logic at(logic [15:0] a, logic [15:0] o);
        return a == o || a == o + (IOMSR_SET_BASE_2 - IOMSR_SET_BASE_1);
    endfunction
    property rng(o, lo, hi);
        rd && at(reg_addr, o) |=> reg_err || (reg_rdata >= lo && reg_rdata <= hi);
    endproperty
    chk_ack_one_cycle: assert property (reg_req |=> reg_ack) else $error("ack late");
    chk_no_stray_ack: assert property (!reg_req |=> !reg_ack && !reg_err) else $error("stray ack");
    chk_idle_data_zero: assert property (!reg_ack |-> reg_rdata == 16'h0000) else $error("idle data");
    chk_write_no_data: assert property (reg_req && reg_we |=> reg_rdata == 16'h0000)
        else $error("write returned data");
    chk_err_data_zero: assert property (reg_err |-> reg_ack && reg_rdata == 16'h0000)
        else $error("error with data");
    chk_app_range: assert property (rng(IOMSR_APP_SEL_OFS, 1, 9)) else $error("app range");
    chk_lock_range: assert property (rng(IOMSR_LOCK_OFS, 0, 1)) else $error("lock range");
    chk_inst_range: assert property (rng(IOMSR_INST_OFS, 0, 1)) else $error("inst range");
    chk_btn_range: assert property (rng(IOMSR_BTN_APP_OFS, 1, 9)) else $error("button range");
    chk_sw_range: assert property (rng(IOMSR_SW_APP_OFS, 1, 9)) else $error("sw range");
    chk_in_rsvd_bits: assert property (rng(IOMSR_IN_STATE_OFS, 0, 63)) else $error("in bits");
    chk_out_rsvd_bits: assert property (rng(IOMSR_OUT_STATE_OFS, 0, 7)) else $error("out bits");
    chk_rsvd_word: assert property (rng(IOMSR_RSVD_SET_OFS, 0, 0)) else $error("rsvd word");
    cover property (rd && reg_addr == IOMSR_BTN_APP_OFS ##1 reg_ack);
    cover property (reg_req && reg_we ##1 reg_ack);
    cover property (reg_err);
endmodule
bind iomsr_top iomsr_assertions chk (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_ack(reg_ack), .reg_err(reg_err),
    .reg_rdata(reg_rdata));
`default_nettype wire

// file: verif/iomsr_master.sv
`timescale 1ns/1ps
`default_nettype none
module iomsr_master (
    // Clock
    input  wire logic        clk,
    // Request side
    output var  logic        reg_req,
    output var  logic        reg_we,
    output var  logic [15:0] reg_addr,
    output var  logic [15:0] reg_wdata,
    // Answer side
    input  wire logic        reg_ack,
    input  wire logic        reg_err,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_req = 1'b0;
        reg_we = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // Answer stands one cycle only, so it is taken just after that edge
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                          output logic [17:0] r);
        @(posedge clk);
        reg_req <= 1'b1;
        reg_we <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_req <= 1'b0;
        #1;
        r = {reg_ack, reg_err, reg_rdata};
    endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import iomsr_pkg::*;
    logic        clk = 0, resetn = 0, lock = 0, inst = 0, btn = 0, sw_val = 0;
    logic [3:0]  app_sw = 4'h1, sw_app = 4'h0, app_e = 4'h1, btn_e = 4'h1, sw_e = 4'h1;
    logic [5:0]  in_l = 0, in_v = 0;
    logic [2:0]  out_l = 0, out_v = 0;
    logic        req, we, ack, err;
    logic [15:0] addr, wdata, rdata, base, oth;
    logic [17:0] rd;
    logic [31:0] r;
    integer      seed = 51, num_errors = 0, check_count = 0, cyc = 0, i, k;
    always #2 clk = ~clk;
    iomsr_top uut (.clk(clk), .resetn(resetn), .app_switch(app_sw), .lock_switch(lock),
        .instance_switch(inst), .test_button(btn), .sw_validate(sw_val), .sw_app(sw_app),
        .input_line(in_l), .input_valid(in_v), .output_line(out_l), .output_valid(out_v),
        .reg_req(req), .reg_we(we), .reg_addr(addr), .reg_wdata(wdata), .reg_ack(ack),
        .reg_err(err), .reg_rdata(rdata));
    iomsr_master m (.clk(clk), .reg_req(req), .reg_we(we), .reg_addr(addr),
        .reg_wdata(wdata), .reg_ack(ack), .reg_err(err), .reg_rdata(rdata));
    task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Word k counts from the settings base; status words follow at k = 8
    function automatic logic [15:0] expw(int k);
        case (k)
            0: expw = {12'h000, app_e};
            1: expw = {15'h0000, lock};
            2: expw = {15'h0000, inst};
            4: expw = {12'h000, btn_e};
            5: expw = {12'h000, sw_e};
            8: expw = {10'h000, in_v};
            9: expw = {10'h000, in_l};
            10: expw = {13'h0000, out_v};
            11: expw = {13'h0000, out_l};
            default: expw = 16'h0000;
        endcase
    endfunction
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        for (i = 0; i < 24; i++) begin
            r = $random(seed);
            if (i < 2) r[3:0] = i ? 4'h9 : 4'h1;
            @(posedge clk);
            {out_v, out_l, in_v, in_l, inst, lock, app_sw} <= r[23:0];
            // Out-of-range selector codes leave the last good position
            if (r[3:0] >= 1 && r[3:0] <= 9) app_e = r[3:0];
            @(posedge clk);
            sw_app <= r[27:24];
            sw_val <= 1'b1;
            if (r[27:24] >= 1 && r[27:24] <= 9) sw_e = r[27:24];
            @(posedge clk);
            sw_val <= 1'b0;
            repeat (8) @(posedge clk);
            if (r[28]) begin
                btn <= 1'b1;
                btn_e = app_e;
                repeat (8) @(posedge clk);
                btn <= 1'b0;
            end
            base = r[5] ? IOMSR_SET_BASE_2 : IOMSR_SET_BASE_1;
            oth = r[5] ? IOMSR_SET_BASE_1 : IOMSR_SET_BASE_2;
            for (k = 0; k < 12; k++) begin
                m.access(1'b0, base + 16'(k), 16'h0000, rd);
                check("word", rd, {2'b10, expw(k)});
                m.access(1'b0, oth + 16'(k), 16'h0000, rd);
                check("other instance", rd, 18'h30000);
            end
            // Later reads prove the write changed nothing
            m.access(1'b1, base + 16'(r[31:29]), 16'hFFFF, rd);
            check("write answer", rd, 18'h20000);
            $display("iteration %0d done", i);
        end
        m.access(1'b0, 16'h38FC, 16'h0000, rd);
        check("below map", rd, 18'h30000);
        m.access(1'b0, 16'h44C1, 16'h0000, rd);
        check("above map", rd, 18'h30000);
        test_done();
    end
endmodule
`default_nettype wire
